// [mcu_data_memory.sv]
// data memory, flags, watchdog and halt/wake control of the small core
`timescale 1ns/1ps
`default_nettype none
module mcu_data_memory
#(
	parameter int         wdt_period_exp = 8,      // n, 8..11
	parameter bit         wdt_enable     = 1'b1,   // build option
	parameter bit         wdt_paired     = 1'b0,   // paired clear mode
	parameter logic [7:0] wake_enable    = 8'hff   // port b wake bits
)
(
	input  wire logic       clock,
	input  wire logic       resetn,            // power-up reset
	input  wire logic       external_reset_pin_n, // pin, active low
	input  wire logic [7:0] port_b_pins,
	input  wire logic [7:0] port_a_pins,
	// core data port
	input  wire logic [5:0] mem_addr,
	input  wire logic       mem_write,
	input  wire logic [7:0] mem_wdata,
	output logic      [7:0] mem_rdata,
	// core alu flag update
	input  wire logic       alu_flags_we,
	input  wire logic [3:0] alu_flags_mask,    // c, ac, z, ov
	input  wire logic [3:0] alu_flags,
	// table read
	input  wire logic       table_last_page,
	input  wire logic [9:0] program_counter,
	input  wire logic       table_load,
	input  wire logic [5:0] table_high_in,
	output logic      [9:0] table_address,
	// housekeeping instructions
	input  wire logic       watchdog_clear_single,
	input  wire logic       watchdog_clear_first,
	input  wire logic       watchdog_clear_second,
	input  wire logic       halt_exec,
	// chip-level outputs
	output logic            halted,
	output logic            core_run,
	output logic            core_pc_reset,     // pc and stack only
	output logic      [7:0] port_a_out,
	output logic      [7:0] port_b_out,
	output logic            port_c_out
);
	typedef enum logic [2:0]
	{
		run_st     = 3'b001,
		halt_st    = 3'b010,
		startup_st = 3'b100
	} mode_type;

	typedef struct packed
	{
		mode_type    mode;
		logic [5:0]  pointer;
		logic [7:0]  acc;
		logic [7:0]  program_counter_low;
		logic [7:0]  table_pointer;
		logic [5:0]  table_high_byte;
		logic [3:0]  alu_f;        // c, ac, z, ov
		logic        pd;
		logic        to;
		logic [7:0]  pa;
		logic [7:0]  pb;
		logic        pc0;
		logic [1:0]  div;          // system to instruction clock
		logic [10:0] wdt;          // prescaler
		logic        first_seen;   // paired clear memory
		logic        second_seen;
		logic [10:0] startup;
		logic [7:0]  rdata;
		logic [9:0]  taddr;
		logic        pc_reset;
		logic [1:0]  rst_meta;     // reset pin synchroniser
	} house_state_type;

	house_state_type state_q;
	house_state_type state_d;
	logic [7:0] ram [mcu_house_pkg::ram_words];
	logic [7:0] b_level;
	logic [7:0] b_fall;
	logic [7:0] a_meta;
	logic [7:0] a_sync;
	logic [5:0] eff_addr;
	logic       eff_null;
	logic [7:0] rd_val;
	logic       pin_reset;
	logic       tick;
	logic       wdt_over;
	logic       clear_ok;
	logic       wake_b;

	// one synchroniser per port b bit for wake-up
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_wake
			mcu_wake_sync u_sync
			(
				.clock  (clock),
				.resetn (resetn),
				.pin    (port_b_pins[gi]),
				.level  (b_level[gi]),
				.fall   (b_fall[gi])
			);
		end
	endgenerate

	// port a inputs are read through two flops too
	always_ff @(posedge clock)
	begin
		a_meta <= port_a_pins;
		a_sync <= a_meta;
	end

	assign pin_reset = ~state_q.rst_meta[1];
	// instruction clock tick once per four system clocks
	assign tick      = (state_q.div == mcu_house_pkg::instr_div_last);
	assign wdt_over  = wdt_enable && tick &&
		(state_q.wdt[wdt_period_exp-1:0] == '1);
	assign wake_b    = |(b_fall & wake_enable);

	// indirect address resolution
	always_comb
	begin
		eff_addr = mem_addr;
		eff_null = 1'b0;
		if (mem_addr == mcu_house_pkg::indirect_access_port_addr)
		begin
			eff_addr = state_q.pointer;
			eff_null = (state_q.pointer == mcu_house_pkg::indirect_access_port_addr);
		end
	end

	// read mux over the decoded map
	always_comb
	begin
		rd_val = mcu_house_pkg::unmapped_read_value;
		if (eff_null)
			rd_val = mcu_house_pkg::unmapped_read_value;
		else if (eff_addr >= mcu_house_pkg::ram_first_addr)
			rd_val = ram[eff_addr[4:0]];
		else
		begin
			case (eff_addr)
				mcu_house_pkg::memory_pointer_addr:
					rd_val = mcu_house_pkg::pointer_top_ones | {2'b00, state_q.pointer};
				mcu_house_pkg::accumulator_addr:         rd_val = state_q.acc;
				mcu_house_pkg::program_counter_low_addr: rd_val = state_q.program_counter_low;
				mcu_house_pkg::table_pointer_addr:       rd_val = state_q.table_pointer;
				mcu_house_pkg::table_high_byte_addr:     rd_val = {2'b00, state_q.table_high_byte};
				mcu_house_pkg::flag_register_addr:
					rd_val = {2'b00, state_q.to, state_q.pd, state_q.alu_f};
				// inputs are not latched: port a and b pins are read, gated by own latch, except port b bits 7..2, read ungated; port c reads its latch
				mcu_house_pkg::port_a_latch_addr:        rd_val = a_sync & state_q.pa;
				mcu_house_pkg::port_b_latch_addr:
					rd_val = {b_level[7:2], b_level[1:0] & state_q.pb[1:0]};
				mcu_house_pkg::port_c_latch_addr:        rd_val = {7'h00, state_q.pc0};
				default:                                 rd_val = mcu_house_pkg::unmapped_read_value;
			endcase
		end
	end

	// ram writes; the array is outside the struct so it maps onto memory
	always_ff @(posedge clock)
	begin
		if (mem_write && !eff_null && state_q.mode == run_st &&
			eff_addr >= mcu_house_pkg::ram_first_addr)
			ram[eff_addr[4:0]] <= mem_wdata;
	end

	// paired-clear completion, first/second may arrive in either order
	assign clear_ok = wdt_paired ?
		((watchdog_clear_first || state_q.first_seen) &&
		 (watchdog_clear_second || state_q.second_seen) &&
		 (watchdog_clear_first || watchdog_clear_second)) :
		watchdog_clear_single;

	// next state
	always_comb
	begin
		state_d          = state_q;
		state_d.rst_meta = {state_q.rst_meta[0], external_reset_pin_n};
		state_d.div      = state_q.div + 2'd1;
		state_d.pc_reset = 1'b0;
		state_d.rdata    = rd_val;
		state_d.taddr    = {table_last_page ? mcu_house_pkg::last_page_bits
			: program_counter[9:8], state_q.table_pointer};
		if (table_load)
			state_d.table_high_byte = table_high_in;
		// register writes from the core
		if (mem_write && !eff_null && state_q.mode == run_st)
		begin
			case (eff_addr)
				mcu_house_pkg::memory_pointer_addr:      state_d.pointer = mem_wdata[5:0];
				mcu_house_pkg::accumulator_addr:         state_d.acc = mem_wdata;
				mcu_house_pkg::program_counter_low_addr: state_d.program_counter_low = mem_wdata;
				mcu_house_pkg::table_pointer_addr:       state_d.table_pointer = mem_wdata;
				mcu_house_pkg::flag_register_addr:
					state_d.alu_f = mem_wdata[3:0] & mcu_house_pkg::flag_write_mask[3:0];
				mcu_house_pkg::port_a_latch_addr:        state_d.pa = mem_wdata;
				mcu_house_pkg::port_b_latch_addr:        state_d.pb = mem_wdata;
				mcu_house_pkg::port_c_latch_addr:        state_d.pc0 = mem_wdata[0];
				default:                                 state_d.pb = state_d.pb;
			endcase
		end
		// alu results take precedence per bit over a move into flags
		if (alu_flags_we)
			state_d.alu_f = (state_d.alu_f & ~alu_flags_mask) |
				(alu_flags & alu_flags_mask);
		// watchdog prescaler; stops while halted
		if (state_q.mode == run_st && tick && wdt_enable)
			state_d.wdt = state_q.wdt + 11'd1;
		// paired-clear memory
		if (wdt_enable && wdt_paired && state_q.mode == run_st)
		begin
			if (watchdog_clear_first)
				state_d.first_seen = 1'b1;
			if (watchdog_clear_second)
				state_d.second_seen = 1'b1;
		end
		case (state_q.mode)
			run_st:
			begin
				if (wdt_enable && halt_exec)
				begin
					state_d.mode = halt_st;
					state_d.wdt  = '0;
					state_d.pd   = 1'b1;
					state_d.to   = 1'b0;
					state_d.first_seen  = 1'b0;
					state_d.second_seen = 1'b0;
				end
				else if (!wdt_enable && halt_exec)
				begin
					state_d.mode = halt_st;
					state_d.pd   = 1'b1;
					state_d.to   = 1'b0;
				end
				else if (wdt_enable && clear_ok)
				begin
					state_d.wdt = '0;
					state_d.pd  = 1'b0;
					state_d.to  = 1'b0;
					state_d.first_seen  = 1'b0;
					state_d.second_seen = 1'b0;
				end
				else if (wdt_over)
				begin
					// overflow restarts from address zero, keeps data
					state_d.to       = 1'b1;
					state_d.pc_reset = 1'b1;
					state_d.wdt      = '0;
				end
			end
			halt_st:
			begin
				// port wake continues at next instruction after the wait
				if (wake_b)
				begin
					state_d.mode    = startup_st;
					state_d.startup = '0;
				end
			end
			startup_st:
			begin
				state_d.startup = state_q.startup + 11'd1;
				if (state_q.startup[9:0] == mcu_house_pkg::startup_last[9:0])
					state_d.mode = run_st;
			end
			default:
				state_d.mode = run_st;
		endcase
		// the reset pin wins: initialise, pd/to stay so software sees the cause
		if (pin_reset)
		begin
			state_d.wdt         = '0;
			state_d.first_seen  = 1'b0;
			state_d.second_seen = 1'b0;
			state_d.pa          = mcu_house_pkg::port_reset_value;
			state_d.pb          = mcu_house_pkg::port_reset_value;
			state_d.pc0         = 1'b1;
			state_d.pc_reset    = 1'b1;
			// waking from halt by pin still pays the start-up wait
			if (state_q.mode != run_st)
			begin
				state_d.mode    = startup_st;
				state_d.startup = '0;
			end
		end
	end

	// register the state; power-up clears pd and to and runs the wait
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			state_q          <= '0;
			state_q.mode     <= startup_st;
			state_q.pa       <= mcu_house_pkg::port_reset_value;
			state_q.pb       <= mcu_house_pkg::port_reset_value;
			state_q.pc0      <= 1'b1;
			state_q.rst_meta <= 2'b11;
			state_q.pc_reset <= 1'b1;
		end
		else
			state_q <= state_d;
	end

	assign mem_rdata     = state_q.rdata;
	assign table_address = state_q.taddr;
	// one-hot mode bits, so both leave straight from the mode flops
	assign halted        = state_q.mode[1];
	assign core_run      = state_q.mode[0];
	assign core_pc_reset = state_q.pc_reset;
	assign port_a_out    = state_q.pa;
	assign port_b_out    = state_q.pb;
	assign port_c_out    = state_q.pc0;

	// flag writes leave timeout and power-down alone
	property p_flag_write_keeps;
		@(posedge clock) disable iff (!resetn)
		(mem_write && core_run && !eff_null && eff_addr == mcu_house_pkg::flag_register_addr
			&& !halt_exec && !clear_ok && !wdt_over && !pin_reset)
		|=> ($stable(state_q.to) && $stable(state_q.pd));
	endproperty
	a_flag_write_keeps: assert property (p_flag_write_keeps) else $error("flag write changed to/pd");

	// halt sets pd and clears to
	property p_halt_flags;
		@(posedge clock) disable iff (!resetn)
		(core_run && halt_exec && !pin_reset) |=> (state_q.pd && !state_q.to && halted);
	endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

	// pointer reads always show ones on top
	property p_pointer_top;
		@(posedge clock) disable iff (!resetn)
		(mem_addr == mcu_house_pkg::memory_pointer_addr) |=> (mem_rdata[7:6] == 2'b11);
	endproperty
	a_pointer_top: assert property (p_pointer_top) else $error("pointer top bits");

	// flag bits 7..6 read zero
	property p_flag_top;
		@(posedge clock) disable iff (!resetn)
		(mem_addr == mcu_house_pkg::flag_register_addr) |=> (mem_rdata[7:6] == 2'b00);
	endproperty
	a_flag_top: assert property (p_flag_top) else $error("flag top bits");

	// last-page table read forces ones
	property p_last_page;
		@(posedge clock) disable iff (!resetn)
		table_last_page |=> (table_address[9:8] == 2'b11 && table_address[7:0] == $past(state_q.table_pointer));
	endproperty
	a_last_page: assert property (p_last_page) else $error("last page address");

	// overflow sets timeout and pulses the pc reset
	property p_overflow;
		@(posedge clock) disable iff (!resetn)
		(core_run && wdt_over && !halt_exec && !clear_ok && !pin_reset) |=> (state_q.to && core_pc_reset);
	endproperty
	a_overflow: assert property (p_overflow) else $error("watchdog overflow");

	// port wake goes through the start-up wait, not straight to run
	property p_wake_wait;
		@(posedge clock) disable iff (!resetn)
		(halted && wake_b && !pin_reset) |=> !core_run [*8];
	endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("wake skipped wait");

	// pointer at zero reads zero through the indirect port
	property p_null_read;
		@(posedge clock) disable iff (!resetn)
		(mem_addr == mcu_house_pkg::indirect_access_port_addr && state_q.pointer == 6'h00)
		|=> (mem_rdata == 8'h00);
	endproperty
	a_null_read: assert property (p_null_read) else $error("indirect null read");
endmodule
`default_nettype wire

// [mcu_data_memory_tb.sv]
// self-checking bench for the data memory, flags, watchdog and halt block
`timescale 1ns/1ps
`default_nettype none
module mcu_data_memory_tb;
	logic       clock, resetn, mem_write, alu_flags_we, table_last_page, table_load;
	logic       clear_single, halt_exec, halted, core_run, core_pc_reset, port_c_out, fall_start;
	logic       clear_first, clear_second, external_reset_pin_n;
	logic [2:0] fall_bit;
	logic [3:0] alu_flags_mask, alu_flags;
	logic [5:0] mem_addr, table_high_in;
	logic [7:0] mem_wdata, mem_rdata, port_a_out, port_b_out, port_a_pins, port_b_pins;
	logic [9:0] program_counter, table_address;
	int         n_errors, check_count, n;

	mcu_data_memory #(.wdt_period_exp(8), .wdt_enable(1'b1), .wdt_paired(1'b0), .wake_enable(8'hff))
		mcu_data_memory_inst (.clock(clock), .resetn(resetn), .external_reset_pin_n(external_reset_pin_n),
		.port_b_pins(port_b_pins), .port_a_pins(port_a_pins), .mem_addr(mem_addr), .mem_write(mem_write),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .alu_flags_we(alu_flags_we),
		.alu_flags_mask(alu_flags_mask), .alu_flags(alu_flags), .table_last_page(table_last_page),
		.program_counter(program_counter), .table_load(table_load), .table_high_in(table_high_in),
		.table_address(table_address), .watchdog_clear_single(clear_single),
		.watchdog_clear_first(clear_first), .watchdog_clear_second(clear_second), .halt_exec(halt_exec),
		.halted(halted), .core_run(core_run), .core_pc_reset(core_pc_reset),
		.port_a_out(port_a_out), .port_b_out(port_b_out), .port_c_out(port_c_out));
	port_b_source port_b_source_inst (.clock(clock), .resetn(resetn), .fall_start(fall_start),
		.fall_bit(fall_bit), .port_b_pins(port_b_pins));

	// free-running system clock, 50 ns period
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// compare a design value bit for bit, unknowns never match
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// compare a measured cycle count against a window
	task automatic check_range(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		mem_addr  <= a;
		mem_write <= 1'b1;
		mem_wdata <= d;
		@(posedge clock);
		mem_write <= 1'b0;
	endtask
	// address held two edges so the registered answer has surely landed
	task automatic read_reg(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clock);
		mem_addr <= a;
		repeat (2) @(posedge clock);
		#1 check(mem_rdata, exp);
	endtask
	task automatic kick;
		@(posedge clock);
		clear_single <= 1'b1;
		@(posedge clock);
		clear_single <= 1'b0;
	endtask
	// count cycles until the core may run again, bounded
	task automatic wait_run;
		n = 0;
		while (core_run !== 1'b1 && n < 3000)
		begin
			@(posedge clock);
			#1 n++;
		end
	endtask

	task automatic test_map;
		kick();
		check(port_a_out, 8'hff);
		check(port_c_out, 1'b1);
		write_reg(mcu_house_pkg::accumulator_addr, 8'h3c);
		read_reg(mcu_house_pkg::accumulator_addr, 8'h3c);
		write_reg(6'h20, 8'ha5);
		write_reg(6'h3f, 8'h5a);
		read_reg(6'h20, 8'ha5);
		read_reg(6'h3f, 8'h5a);
		read_reg(6'h03, 8'h00);
		read_reg(6'h1f, 8'h00);
		write_reg(mcu_house_pkg::port_a_latch_addr, 8'h55);
		#1 check(port_a_out, 8'h55);
		read_reg(mcu_house_pkg::port_a_latch_addr, 8'h55);
		// port a reads see the pins through the latch, after the two-flop delay; port b bits 7..2 read ungated
		@(posedge clock);
		port_a_pins <= 8'h3c;
		@(posedge clock);
		read_reg(mcu_house_pkg::port_a_latch_addr, 8'h14);
		write_reg(mcu_house_pkg::port_b_latch_addr, 8'h00);
		#1 check(port_b_out, 8'h00);
		read_reg(mcu_house_pkg::port_b_latch_addr, 8'hfc);
		write_reg(mcu_house_pkg::memory_pointer_addr, 8'h20);
		read_reg(mcu_house_pkg::memory_pointer_addr, 8'he0);
		$display("map test done");
	endtask
	task automatic test_indirect;
		kick();
		write_reg(mcu_house_pkg::memory_pointer_addr, 8'h21);
		write_reg(6'h00, 8'h77);
		read_reg(6'h21, 8'h77);
		read_reg(6'h00, 8'h77);
		write_reg(mcu_house_pkg::memory_pointer_addr, 8'h00);
		write_reg(6'h00, 8'h99);
		read_reg(6'h00, 8'h00);
		read_reg(6'h21, 8'h77);
		$display("indirect test done");
	endtask
	task automatic test_flags;
		kick();
		write_reg(mcu_house_pkg::flag_register_addr, 8'hff);
		read_reg(mcu_house_pkg::flag_register_addr, 8'h0f);
		@(posedge clock);
		alu_flags_we   <= 1'b1;
		alu_flags_mask <= 4'b0110;
		alu_flags      <= 4'b0000;
		@(posedge clock);
		alu_flags_we <= 1'b0;
		read_reg(mcu_house_pkg::flag_register_addr, 8'h09);
		$display("flags test done");
	endtask
	task automatic test_table;
		kick();
		write_reg(mcu_house_pkg::table_pointer_addr, 8'h5a);
		program_counter <= 10'h2c3;
		repeat (2) @(posedge clock);
		#1 check(table_address, 10'h25a);
		@(posedge clock);
		table_last_page <= 1'b1;
		repeat (2) @(posedge clock);
		#1 check(table_address, 10'h35a);
		@(posedge clock);
		table_load    <= 1'b1;
		table_high_in <= 6'h2a;
		@(posedge clock);
		table_load <= 1'b0;
		write_reg(mcu_house_pkg::table_high_byte_addr, 8'hff);
		read_reg(mcu_house_pkg::table_high_byte_addr, 8'h2a);
		$display("table test done");
	endtask
	task automatic test_timeout;
		write_reg(mcu_house_pkg::flag_register_addr, 8'h00);
		kick();
		// in single clear mode the paired instructions must not clear the watchdog
		repeat (500) @(posedge clock);
		clear_first  <= 1'b1;
		clear_second <= 1'b1;
		@(posedge clock);
		clear_first  <= 1'b0;
		clear_second <= 1'b0;
		n = 501;
		while (core_pc_reset !== 1'b1 && n < 3000)
		begin
			@(posedge clock);
			#1 n++;
		end
		check_range(n, 1016, 1032);
		wait_run();
		read_reg(mcu_house_pkg::flag_register_addr, 8'h20);
		$display("timeout test done");
	endtask
	// reset pin in run: ports and prescaler start over, flags kept, no start-up wait
	task automatic test_pin_reset;
		write_reg(mcu_house_pkg::port_a_latch_addr, 8'h0f);
		// late in the period, so a prescaler left uncleared would overflow early
		repeat (600) @(posedge clock);
		external_reset_pin_n <= 1'b0;
		n = 0;
		repeat (6)
		begin
			@(posedge clock);
			#1 n += (core_pc_reset === 1'b1);
		end
		check_range(n, 2, 6);
		@(posedge clock);
		external_reset_pin_n <= 1'b1;
		repeat (4) @(posedge clock);
		#1 n = 4;
		check({port_a_out, port_b_out}, 16'hffff);
		check({port_c_out, core_run}, 2'h3);
		read_reg(mcu_house_pkg::flag_register_addr, 8'h20);
		n += 3;
		while (core_pc_reset !== 1'b1 && n < 3000)
		begin
			@(posedge clock);
			#1 n++;
		end
		check_range(n, 1016, 1036);
		$display("pin reset test done");
	endtask
	task automatic test_halt;
		@(posedge clock);
		halt_exec <= 1'b1;
		@(posedge clock);
		halt_exec <= 1'b0;
		@(posedge clock);
		#1 check({halted, core_run}, 2'b10);
		n = 0;
		repeat (1200) @(posedge clock) n += (core_pc_reset === 1'b1);
		check(n, 0);
		fall_start <= 1'b1;
		fall_bit   <= 3'd3;
		@(posedge clock);
		fall_start <= 1'b0;
		wait_run();
		check_range(n, 1024, 1036);
		check(halted, 1'b0);
		read_reg(mcu_house_pkg::flag_register_addr, 8'h10);
		kick();
		read_reg(mcu_house_pkg::flag_register_addr, 8'h00);
		// second halt, left by the reset pin: the start-up wait applies again
		@(posedge clock);
		halt_exec <= 1'b1;
		@(posedge clock);
		halt_exec <= 1'b0;
		repeat (4) @(posedge clock);
		external_reset_pin_n <= 1'b0;
		repeat (4) @(posedge clock);
		external_reset_pin_n <= 1'b1;
		wait_run();
		check_range(n, 1024, 1036);
		read_reg(mcu_house_pkg::flag_register_addr, 8'h10);
		$display("halt test done");
	endtask

	// main sequence: reset, start-up wait, then each scenario in turn
	initial
	begin
		n_errors = 0;
		check_count = 0;
		{resetn, mem_write, alu_flags_we, table_last_page, table_load, clear_single, halt_exec} = 7'h00;
		{fall_start, fall_bit, alu_flags_mask, alu_flags} = 12'h000;
		{mem_addr, table_high_in, mem_wdata, program_counter} = 30'h0000_0000;
		{external_reset_pin_n, clear_first, clear_second} = 3'h4;
		port_a_pins = 8'hff;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		wait_run();
		check_range(n, 1024, 1030);
		test_map();
		test_indirect();
		test_flags();
		test_table();
		test_timeout();
		test_pin_reset();
		test_halt();
		final_report();
	end
	// hang guard, a little over twice the expected run
	initial
	begin
		#(16000 * 50);
		n_errors++;
		$display("watchdog limit reached at %0t", $time);
		final_report();
	end
endmodule
`default_nettype wire

// [mcu_house_pkg.sv]
// package: address map, flag layout, watchdog options and timing constants
package mcu_house_pkg;
	// data memory map
	localparam logic [5:0] indirect_access_port_addr = 6'h00;
	localparam logic [5:0] memory_pointer_addr       = 6'h01;
	localparam logic [5:0] accumulator_addr          = 6'h05;
	localparam logic [5:0] program_counter_low_addr  = 6'h06;
	localparam logic [5:0] table_pointer_addr        = 6'h07;
	localparam logic [5:0] table_high_byte_addr      = 6'h08;
	localparam logic [5:0] flag_register_addr        = 6'h0a;
	localparam logic [5:0] port_a_latch_addr         = 6'h12;
	localparam logic [5:0] port_b_latch_addr         = 6'h14;
	localparam logic [5:0] port_c_latch_addr         = 6'h16;
	localparam logic [5:0] ram_first_addr            = 6'h20;
	localparam int         ram_words                 = 32;
	// flag register bit positions
	localparam int carry_bit      = 0;
	localparam int half_carry_bit = 1;
	localparam int zero_bit       = 2;
	localparam int overflow_bit   = 3;
	localparam int power_down_bit = 4;
	localparam int timeout_bit    = 5;
	// read values of fixed bits
	localparam logic [7:0] unmapped_read_value = 8'h00;
	localparam logic [7:0] pointer_top_ones    = 8'hc0;
	localparam logic [7:0] flag_write_mask     = 8'h0f;
	localparam logic [1:0] last_page_bits      = 2'h3;
	// reset values
	localparam logic [7:0] port_reset_value    = 8'hff;
	localparam logic [7:0] zero_byte           = 8'h00;
	// instruction clock is the system clock divided by four
	localparam int         instr_div_bits      = 2;
	localparam logic [1:0] instr_div_last      = 2'h3;
	// watchdog prescaler, long enough for n = 11
	localparam int         wdt_bits            = 11;
	// start-up wait after wake-up, in system clock periods
	localparam int         startup_periods     = 1024;
	localparam int         startup_cycles      = startup_periods;
	localparam logic [10:0] startup_last       = 11'h3ff;
endpackage

// [mcu_wake_sync.sv]
// two-stage synchroniser with falling-edge detect for one pin
`timescale 1ns/1ps
`default_nettype none
module mcu_wake_sync
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic pin,
	output logic      level,
	output logic      fall
);
	typedef struct packed
	{
		logic meta;  // first stage, read only by the second
		logic sync;  // second stage
		logic prev;  // delayed copy for edge detect
	} sync_state_type;

	sync_state_type state_q;
	sync_state_type state_d;

	// next state: shift the pin through; idle level is high (pull-up)
	always_comb
	begin
		state_d      = state_q;
		state_d.meta = pin;
		state_d.sync = state_q.meta;
		state_d.prev = state_q.sync;
	end

	// register the state
	always_ff @(posedge clock)
	begin
		if (!resetn)
			state_q <= '1;
		else
			state_q <= state_d;
	end

	assign level = state_q.sync;
	assign fall  = state_q.prev & ~state_q.sync;
endmodule
`default_nettype wire

// [port_b_source.sv]
// port b wake-up source: pulled-up pins that can be pulled low on command
`timescale 1ns/1ps
`default_nettype none
module port_b_source
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       fall_start, // one-cycle command from the bench
	input  wire logic [2:0] fall_bit,   // which pin to pull low
	output logic      [7:0] port_b_pins
);
	logic [3:0] low_count; // cycles left with the pin held low
	logic [2:0] low_bit;   // pin being held low
	// hold the pin low long enough for the two-flop synchroniser to see it
	always_ff @(posedge clock)
	begin
		if (!resetn)
			low_count <= 4'h0;
		else if (fall_start)
		begin
			low_count <= 4'h8;
			low_bit   <= fall_bit;
		end
		else if (low_count != 4'h0)
			low_count <= low_count - 4'h1;
	end
	// released pins float to the pull-up level, never to the last value
	assign port_b_pins = (low_count != 4'h0) ? ~(8'h01 << low_bit) : 8'hff;
endmodule
`default_nettype wire
